// *** design/uem_pkg.sv ***
package uem_pkg;

    // register byte addresses
    localparam logic [11:0] UEM_STATUS_ADDR   = 12'h104;
    localparam logic [11:0] UEM_MASK_ADDR     = 12'h108;
    localparam logic [11:0] UEM_CONTROL_ADDR  = 12'h118;
    localparam logic [11:0] UEM_HDR_LOG_ADDR  = 12'h11C;
    localparam logic [11:0] UEM_IRQ_STAT_ADDR = 12'h120;
    localparam logic [11:0] UEM_IRQ_MASK_ADDR = 12'h124;

    // error class bit positions
    localparam int UEM_OBSOLETE_POS   = 0;
    localparam int UEM_LINK_PROTO_POS = 4;
    localparam int UEM_SURPRISE_POS   = 5;
    localparam int UEM_POISONED_POS   = 12;
    localparam int UEM_FLOW_CTRL_POS  = 13;
    localparam int UEM_COMPL_TO_POS   = 14;
    localparam int UEM_COMPL_ABT_POS  = 15;
    localparam int UEM_UNEXP_CPL_POS  = 16;
    localparam int UEM_RCV_OVFL_POS   = 17;

    // writable mask bits and live status bits
    localparam logic [31:0] UEM_IMPL_BITS = 32'h0003_3031;
    // classes that take part in logging and reporting
    localparam logic [31:0] UEM_LIVE_BITS = 32'h0003_3030;

    // control register fields
    localparam int UEM_FEP_LSB   = 0;
    localparam int UEM_FEP_W     = 5;
    localparam int UEM_FEP_V_POS = 8;

    // interrupt status fields
    localparam int UEM_IRQ_REPORT_POS = 0;
    localparam int UEM_IRQ_MASKED_POS = 1;
    localparam int UEM_IRQ_W          = 2;

    // reset values
    localparam logic [31:0] UEM_MASK_RST     = 32'h0000_0000;
    localparam logic [31:0] UEM_STATUS_RST   = 32'h0000_0000;
    localparam logic [31:0] UEM_HDR_LOG_RST  = 32'h0000_0000;
    localparam logic [4:0]  UEM_FEP_RST      = 5'h00;
    localparam logic [1:0]  UEM_IRQ_RST      = 2'h0;
    localparam logic [31:0] UEM_UNMAPPED_VAL = 32'h0000_0000;

    typedef enum logic [1:0] {
        UEM_BUS_IDLE = 2'b00,
        UEM_BUS_ACK  = 2'b01
    } uem_bus_state_type;

endpackage : uem_pkg

// *** design/uem_err_filter.sv ***
`timescale 1ns/10ps
module uem_err_filter
    import uem_pkg::*;
(
    input  wire logic [31:0] evt_i,
    input  wire logic [31:0] mask_i,
    output logic      [31:0] unmasked_o,
    output logic      [31:0] masked_o,
    output logic             any_unmasked_o,
    output logic             any_masked_o,
    output logic      [4:0]  first_idx_o
);
    import uem_pkg::*;

    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : lowest_set

    always_comb begin
        unmasked_o     = evt_i & UEM_LIVE_BITS & ~mask_i;
        masked_o       = evt_i & UEM_LIVE_BITS & mask_i;
        any_unmasked_o = |unmasked_o;
        any_masked_o   = |masked_o;
        first_idx_o    = lowest_set(unmasked_o);
    end

endmodule : uem_err_filter

// *** design/uem_regs.sv ***
// Notes on behaviour
// - mask bits 4 and 5 writable
// - mask bits 12 and 13 writable
// - mask bits 16 and 17 writable
// - masked error never logged in header log
// - masked error leaves first error pointer
// - masked error sends no upstream report
// - mask never changes the status bit
// - bit 14 reads zero, ignores writes
// - bit 15 reads zero, ignores writes
// - bit 0 plain storage, no effect
// - status 12 set by hardware, write-one clears
`timescale 1ns/10ps
module uem_regs
    import uem_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hot_rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [31:0] err_event_i,
    input  wire logic [31:0] err_header_i,
    output logic             err_report_o,
    output logic      [4:0]  err_report_idx_o,
    output logic      [31:0] uncorr_err_mask_o,
    output logic      [4:0]  first_error_pointer_o,
    output logic             first_error_valid_o,
    output logic             irq_o
);
    import uem_pkg::*;

    typedef struct packed {
        uem_bus_state_type bus;
        logic [31:0]       rdata;
        logic [31:0]       mask;
        logic [31:0]       status;
        logic [4:0]        fep;
        logic              fep_valid;
        logic [31:0]       hdr_log;
        logic [1:0]        irq_stat;
        logic [1:0]        irq_mask;
        logic              report;
        logic [4:0]        report_idx;
    } uem_state_type;

    uem_state_type st_q;
    uem_state_type st_d;

    logic [31:0] unmasked;
    logic [31:0] masked;
    logic        any_unmasked;
    logic        any_masked;
    logic [4:0]  first_idx;

    uem_err_filter u_filter (
        .evt_i          (err_event_i),
        .mask_i         (st_q.mask),
        .unmasked_o     (unmasked),
        .masked_o       (masked),
        .any_unmasked_o (any_unmasked),
        .any_masked_o   (any_masked),
        .first_idx_o    (first_idx)
    );

    function automatic logic [31:0] byte_lanes(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[b*8 +: 8] = 8'hFF;
            end
        end
        return m;
    endfunction : byte_lanes

    function automatic logic [31:0] read_mux(
        input logic [11:0]   adr,
        input uem_state_type s
    );
        logic [31:0] v;
        v = UEM_UNMAPPED_VAL;
        case (adr)
            UEM_STATUS_ADDR: begin
                v = s.status & UEM_IMPL_BITS;
            end
            UEM_MASK_ADDR: begin
                v = s.mask & UEM_IMPL_BITS;
            end
            UEM_CONTROL_ADDR: begin
                v[UEM_FEP_LSB +: UEM_FEP_W] = s.fep;
                v[UEM_FEP_V_POS]            = s.fep_valid;
            end
            UEM_HDR_LOG_ADDR: begin
                v = s.hdr_log;
            end
            UEM_IRQ_STAT_ADDR: begin
                v[UEM_IRQ_W-1:0] = s.irq_stat;
            end
            UEM_IRQ_MASK_ADDR: begin
                v[UEM_IRQ_W-1:0] = s.irq_mask;
            end
            default: begin
                v = UEM_UNMAPPED_VAL;
            end
        endcase
        return v;
    endfunction : read_mux

    logic        req;
    logic        wr_take;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic        wr_mask;
    logic        wr_status;
    logic        wr_irq_stat;
    logic        wr_irq_mask;
    logic [31:0] status_clr;
    logic [1:0]  irq_clr;
    logic [1:0]  irq_set;
    logic        fep_cleared;

    always_comb begin
        req         = wb_cyc_i && wb_stb_i;
        wr_take     = (st_q.bus == UEM_BUS_ACK) && req && wb_we_i;
        wmask       = byte_lanes(wb_sel_i);
        wbits       = wb_dat_i & wmask;
        wr_mask     = wr_take && (wb_adr_i == UEM_MASK_ADDR);
        wr_status   = wr_take && (wb_adr_i == UEM_STATUS_ADDR);
        wr_irq_stat = wr_take && (wb_adr_i == UEM_IRQ_STAT_ADDR);
        wr_irq_mask = wr_take && (wb_adr_i == UEM_IRQ_MASK_ADDR);
        status_clr  = wr_status ? (wbits & UEM_IMPL_BITS) : 32'h0000_0000;
        irq_clr     = wr_irq_stat ? wbits[UEM_IRQ_W-1:0] : 2'h0;
        irq_set     = 2'h0;
        irq_set[UEM_IRQ_REPORT_POS] = any_unmasked;
        irq_set[UEM_IRQ_MASKED_POS] = any_masked;
        fep_cleared = status_clr[st_q.fep] && !err_event_i[st_q.fep];
    end

    always_comb begin
        st_d        = st_q;
        st_d.report = 1'b0;

        // bus handshake: answer one cycle after the request is seen
        unique case (st_q.bus)
            UEM_BUS_IDLE: begin
                if (req) begin
                    st_d.bus   = UEM_BUS_ACK;
                    st_d.rdata = read_mux(wb_adr_i, st_q);
                end
            end
            UEM_BUS_ACK: begin
                st_d.bus = UEM_BUS_IDLE;
            end
        endcase

        // mask register, writable bits only
        if (wr_mask) begin
            st_d.mask = (st_q.mask & ~(wmask & UEM_IMPL_BITS))
                      | (wbits & UEM_IMPL_BITS);
        end

        // status: new events win over a same-cycle clear, mask unused
        st_d.status = ((st_q.status & ~status_clr)
                    | (err_event_i & UEM_IMPL_BITS)) & UEM_IMPL_BITS;

        // first error pointer frees when its status bit is cleared
        if (st_q.fep_valid && fep_cleared) begin
            st_d.fep_valid = 1'b0;
        end

        // only unmasked errors log, point and report
        if (any_unmasked) begin
            st_d.report     = 1'b1;
            st_d.report_idx = first_idx;
            if (!st_q.fep_valid || fep_cleared) begin
                st_d.fep       = first_idx;
                st_d.fep_valid = 1'b1;
                st_d.hdr_log   = err_header_i;
            end
        end

        // interrupt status, set beats clear
        st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
        if (wr_irq_mask) begin
            st_d.irq_mask = (st_q.irq_mask & ~wmask[UEM_IRQ_W-1:0])
                          | wbits[UEM_IRQ_W-1:0];
        end

        // hot reset spares sticky mask, status, pointer and log
        if (hot_rst_i) begin
            st_d.bus      = UEM_BUS_IDLE;
            st_d.rdata    = 32'h0000_0000;
            st_d.irq_stat = UEM_IRQ_RST;
            st_d.irq_mask = UEM_IRQ_RST;
            st_d.report   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q.bus        <= UEM_BUS_IDLE;
            st_q.rdata      <= 32'h0000_0000;
            st_q.mask       <= UEM_MASK_RST;
            st_q.status     <= UEM_STATUS_RST;
            st_q.fep        <= UEM_FEP_RST;
            st_q.fep_valid  <= 1'b0;
            st_q.hdr_log    <= UEM_HDR_LOG_RST;
            st_q.irq_stat   <= UEM_IRQ_RST;
            st_q.irq_mask   <= UEM_IRQ_RST;
            st_q.report     <= 1'b0;
            st_q.report_idx <= UEM_FEP_RST;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        wb_ack_o              = (st_q.bus == UEM_BUS_ACK) && req;
        wb_dat_o              = st_q.rdata;
        err_report_o          = st_q.report;
        err_report_idx_o      = st_q.report_idx;
        uncorr_err_mask_o     = st_q.mask & UEM_IMPL_BITS;
        first_error_pointer_o = st_q.fep;
        first_error_valid_o   = st_q.fep_valid;
        irq_o                 = |(st_q.irq_stat & st_q.irq_mask);
    end

endmodule : uem_regs

// *** verif/uem_err_src.sv ***
`timescale 1ns/10ps
module uem_err_src (
    input  wire logic        clk_i,
    output logic      [31:0] err_event_o,
    output logic      [31:0] err_header_o
);
    initial err_event_o = 32'h0000_0000;
    initial err_header_o = 32'h0000_0000;
    // one-cycle class pulse, header inverted after it
    task pulse(input logic [31:0] evt, input logic [31:0] hdr);
        @(posedge clk_i);
        err_event_o  <= evt;
        err_header_o <= hdr;
        @(posedge clk_i);
        err_event_o  <= 32'h0000_0000;
        err_header_o <= ~hdr;
    endtask : pulse
endmodule : uem_err_src

// *** verif/uem_regs_props.sv ***
`timescale 1ns/10ps
module uem_regs_props
    import uem_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        hot_rst_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] err_event_i,
    input wire logic        err_report_o,
    input wire logic [4:0]  err_report_idx_o,
    input wire logic [31:0] uncorr_err_mask_o,
    input wire logic [4:0]  first_error_pointer_o,
    input wire logic        first_error_valid_o
);
    import uem_pkg::*;
    logic        [31:0] live;
    logic               wr_mask;
    logic               wr_status;
    assign live = err_event_i & UEM_LIVE_BITS & ~uncorr_err_mask_o;
    assign wr_mask = wb_ack_o && wb_we_i && wb_adr_i == UEM_MASK_ADDR;
    assign wr_status = wb_ack_o && wb_we_i && wb_adr_i == UEM_STATUS_ADDR;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || hot_rst_i);
    a_mask_impl_only: assert property (
        (uncorr_err_mask_o & ~UEM_IMPL_BITS) == 32'h0)
        else $error("mask holds a fixed bit");
    a_mask_write_only: assert property (disable iff (rst_i)
        !wr_mask |=> $stable(uncorr_err_mask_o))
        else $error("mask changed without write");
    a_mask_write_val: assert property (
        wr_mask && wb_sel_i == 4'hF |=>
        uncorr_err_mask_o == ($past(wb_dat_i) & 32'h0003_3031))
        else $error("mask write value wrong");
    a_report_cause: assert property (
        err_report_o |-> $past(live != 32'h0))
        else $error("report without unmasked error");
    a_report_unmasked: assert property (
        live != 32'h0 |=> err_report_o)
        else $error("unmasked error not reported");
    a_ptr_held: assert property (
        !first_error_valid_o && live == 32'h0 |=> !first_error_valid_o)
        else $error("pointer loaded by masked error");
    a_ptr_loaded: assert property (
        !first_error_valid_o && live != 32'h0 |=> first_error_valid_o
        && first_error_pointer_o == err_report_idx_o)
        else $error("pointer not loaded");
    a_ptr_frozen: assert property (
        first_error_valid_o && !wr_status |=>
        first_error_valid_o && $stable(first_error_pointer_o))
        else $error("valid pointer overwritten");
endmodule : uem_regs_props
bind uem_regs uem_regs_props i_props (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .hot_rst_i             (hot_rst_i),
    .wb_ack_o              (wb_ack_o),
    .wb_we_i               (wb_we_i),
    .wb_adr_i              (wb_adr_i),
    .wb_sel_i              (wb_sel_i),
    .wb_dat_i              (wb_dat_i),
    .err_event_i           (err_event_i),
    .err_report_o          (err_report_o),
    .err_report_idx_o      (err_report_idx_o),
    .uncorr_err_mask_o     (uncorr_err_mask_o),
    .first_error_pointer_o (first_error_pointer_o),
    .first_error_valid_o   (first_error_valid_o)
);

// *** verif/uncorrectable_error_mask_tb_top.sv ***
`timescale 1ns/10ps
module uncorrectable_error_mask_tb_top;
    import uem_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, hot_rst_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [3:0]  wsel = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, err_event_i, err_header_i;
    logic [31:0] uncorr_err_mask_o, rd;
    logic        wb_ack_o, err_report_o, first_error_valid_o, irq_o;
    logic [4:0]  err_report_idx_o, first_error_pointer_o;
    int          error_cnt = 0, n_compared = 0;
    uem_regs i_dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .hot_rst_i             (hot_rst_i),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_adr_i              (wb_adr_i),
        .wb_sel_i              (wb_sel_i),
        .wb_dat_i              (wb_dat_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .err_event_i           (err_event_i),
        .err_header_i          (err_header_i),
        .err_report_o          (err_report_o),
        .err_report_idx_o      (err_report_idx_o),
        .uncorr_err_mask_o     (uncorr_err_mask_o),
        .first_error_pointer_o (first_error_pointer_o),
        .first_error_valid_o   (first_error_valid_o),
        .irq_o                 (irq_o)
    );
    uem_err_src i_src (.clk_i, .err_event_o(err_event_i),
                       .err_header_o(err_header_i));
    initial forever #2 clk_i = ~clk_i;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= wsel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task t_reset;
        rdchk(UEM_MASK_ADDR, 32'h0);
        rdchk(12'h200, 32'h0);
        wb(1'b1, UEM_MASK_ADDR, 32'hFFFF_FFFF);
        rdchk(UEM_MASK_ADDR, 32'h0003_3031);
        wb(1'b1, UEM_MASK_ADDR, 32'h0000_CFCE);
        rdchk(UEM_MASK_ADDR, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task t_masked;
        wb(1'b1, UEM_MASK_ADDR, 32'h0003_3031);
        wb(1'b1, UEM_IRQ_MASK_ADDR, 32'h2);
        i_src.pulse(32'h0003_3030, 32'h1234_5678);
        #1 chk(32'(err_report_o), 32'h0);
        chk(32'(irq_o), 32'h1);
        rdchk(UEM_STATUS_ADDR, 32'h0003_3030);
        rdchk(UEM_HDR_LOG_ADDR, 32'h0);
        rdchk(UEM_CONTROL_ADDR, 32'h0);
        wb(1'b1, UEM_IRQ_STAT_ADDR, 32'h2);
        #1 chk(32'(irq_o), 32'h0);
        wb(1'b1, UEM_STATUS_ADDR, 32'hFFFF_FFFF);
        rdchk(UEM_STATUS_ADDR, 32'h0);
        $display("t_masked done");
    endtask : t_masked
    task t_unmasked;
        int p[6];
        p = '{4, 5, 12, 13, 16, 17};
        wb(1'b1, UEM_MASK_ADDR, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            i_src.pulse(32'h1 << p[i], 32'hA5A5_0000 | 32'(p[i]));
            #1 chk(32'(err_report_o), 32'h1);
            chk(32'(err_report_idx_o), 32'(p[i]));
        end
        chk(32'(irq_o), 32'h0);
        rdchk(UEM_CONTROL_ADDR, 32'h0000_0104);
        rdchk(UEM_HDR_LOG_ADDR, 32'hA5A5_0004);
        i_src.pulse(32'h1, 32'h0);
        #1 chk(32'(err_report_o), 32'h0);
        rdchk(UEM_STATUS_ADDR, 32'h0003_3031);
        wb(1'b1, UEM_IRQ_MASK_ADDR, 32'h1);
        #1 chk(32'(irq_o), 32'h1);
        wb(1'b1, UEM_IRQ_STAT_ADDR, 32'h3);
        #1 chk(32'(irq_o), 32'h0);
        wb(1'b1, UEM_STATUS_ADDR, 32'h0000_1000);
        rdchk(UEM_STATUS_ADDR, 32'h0003_2031);
        $display("t_unmasked done");
    endtask : t_unmasked
    task t_hot;
        wb(1'b1, UEM_MASK_ADDR, 32'h0002_0010);
        @(posedge clk_i);
        hot_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        hot_rst_i <= 1'b0;
        rdchk(UEM_MASK_ADDR, 32'h0002_0010);
        rdchk(UEM_IRQ_MASK_ADDR, 32'h0);
        rdchk(UEM_STATUS_ADDR, 32'h0003_2031);
        wsel = 4'h2;
        wb(1'b1, UEM_MASK_ADDR, 32'hFFFF_FFFF);
        wsel = 4'hF;
        rdchk(UEM_MASK_ADDR, 32'h0002_3010);
        $display("t_hot done");
    endtask : t_hot
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_masked();
        t_unmasked();
        t_hot();
        test_done();
    end
    initial begin
        #20000;
        error_cnt++;
        test_done();
    end
endmodule : uncorrectable_error_mask_tb_top
